// ===== tb_tmw_timer.sv
// self-checking testbench for the waveform timer
`timescale 1ns/1ps
`include "tmw_defines.svh"
module tb_tmw_timer;
   import tmw_pkg::*;
   typedef struct {
      logic [11:0] a;
      logic [7:0] d;
      logic [7:0] e;
      logic err;
   } tmw_row_s;
   localparam logic [11:0] CA = `TMW_OFS_CTRL_A << 2;
   localparam logic [11:0] CB = `TMW_OFS_CTRL_B << 2;
   localparam logic [11:0] CN = `TMW_OFS_COUNT << 2;
   localparam logic [11:0] PA = `TMW_OFS_CMP_A << 2;
   localparam logic [11:0] PB = `TMW_OFS_CMP_B << 2;
   localparam logic [11:0] ST = `TMW_OFS_IRQ_STAT << 2;
   localparam logic [11:0] MK = `TMW_OFS_IRQ_MASK << 2;
   logic pclk, presetn, ce, tick, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, wa, wb, oa, ob, irq, dir, pin, er;
   logic [7:0] rd;
   int miscompares, n_checks;
   tmw_row_s rows [6];
   logic [1:0] fld [4] = '{2'd3, 2'd2, 2'd1, 2'd1};
   logic exw [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   tmw_timer dut (.pclk(pclk), .presetn(presetn), .ce(ce), .tick(tick),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .chan_a_wave_out(wa), .chan_b_wave_out(wb), .chan_a_override(oa),
      .chan_b_override(ob), .irq(irq));
   tmw_pin_model pin_a (.override(oa), .wave(wa), .port_data(1'b0),
      .dir(dir), .pin(pin));

   // 200 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   ////////////////////////////////////////
   task chk(input string n, input logic [7:0] x, input logic [7:0] g);
      n_checks++;
      if (g !== x) begin
         $display("MISMATCH %s expected %h seen %h", n, x, g);
         miscompares++;
      end
   endtask
   task chw(input logic ea, input logic eb);
      chk("wave_a", {7'h0, ea}, {7'h0, wa});
      chk("wave_b", {7'h0, eb}, {7'h0, wb});
   endtask
   task complete_run;
      if (miscompares == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // one apb transfer: setup, then access until ready
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task ticks(input int n);
      @(posedge pclk);
      tick <= 1'b1;
      repeat (n) @(posedge pclk);
      tick <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   // load count one below c, then run n ticks
   task hit(input logic [7:0] c, input int n);
      apb(1'b1, CN, c - 8'h1);
      ticks(n);
   endtask
   // hang guard
   initial begin
      repeat (8000) @(posedge pclk);
      miscompares++;
      complete_run();
   end
   ////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, tick, presetn, paddr, pwdata} = '0;
      {miscompares, n_checks} = '0;
      ce = 1'b1;
      dir = 1'b1;
      rows = '{'{CA, 8'hff, 8'hf3, 1'b0}, '{CB, 8'hff, 8'h08, 1'b0},
         '{PA, 8'h5a, 8'h5a, 1'b0}, '{PB, 8'ha5, 8'ha5, 1'b0},
         '{MK, 8'hff, 8'h07, 1'b0}, '{12'h3fc, 8'h11, 8'h00, 1'b1}};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 8'h0);
         if (!rows[i].err) chk("reset", 8'h0, rd);
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 8'h0);
         chk("pslverr", {7'h0, rows[i].err}, {7'h0, er});
         if (!rows[i].err) chk("readback", rows[i].e, rd);
      end
      apb(1'b1, CA, 8'h0);
      apb(1'b1, CB, 8'h0);
      apb(1'b1, MK, 8'h0);
      apb(1'b1, PA, 8'h40);
      apb(1'b1, PB, 8'h40);
      // normal mode: set, clear, toggle, toggle on match
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, CA, {fld[i], fld[i], 4'h0});
         hit(8'h40, 3);
         chw(exw[i], exw[i]);
         chk("override", 8'h03, {6'h0, oa, ob});
         chk("pin", {7'h0, exw[i]}, {7'h0, pin});
      end
      // driver off: pull-up shows through
      dir <= 1'b0;
      @(posedge pclk);
      chk("pin_off", 8'h01, {7'h0, pin});
      dir <= 1'b1;
      // overflow at max: masked, unmasked, frozen, cleared
      apb(1'b1, ST, 8'h07);
      hit(8'hff, 3);
      chk("irq_masked", 8'h0, {7'h0, irq});
      apb(1'b0, ST, 8'h0);
      chk("ovf_max", 8'h01, rd & 8'h01);
      apb(1'b1, MK, 8'h01);
      repeat (2) @(posedge pclk);
      chk("irq", 8'h01, {7'h0, irq});
      ce <= 1'b0;
      ticks(5);
      ce <= 1'b1;
      apb(1'b0, CN, 8'h0);
      chk("frozen", 8'h01, rd);
      apb(1'b1, ST, 8'h01);
      repeat (2) @(posedge pclk);
      chk("irq_clr", 8'h0, {7'h0, irq});
      // clear on match: count wraps after compare a
      apb(1'b1, CA, 8'h42);
      hit(8'h40, 2);
      apb(1'b0, CN, 8'h0);
      chk("ctc_wrap", 8'h00, rd);
      chw(1'b1, 1'b0);
      // fast pwm non-inverting, then compare at top
      apb(1'b1, MK, 8'h0);
      apb(1'b1, CA, 8'ha3);
      hit(8'hff, 4);
      chw(1'b1, 1'b1);
      // new compare values wait for the period end
      apb(1'b1, PA, 8'h80);
      apb(1'b1, PB, 8'h80);
      hit(8'h40, 3);
      chw(1'b0, 1'b0);
      apb(1'b1, PA, 8'hff);
      apb(1'b1, PB, 8'hff);
      hit(8'hff, 4);
      chw(1'b1, 1'b1);
      hit(8'hff, 2);
      chw(1'b1, 1'b1);
      // second reset, then phase correct pwm
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      chk("override_rst", 8'h0, {6'h0, oa, ob});
      apb(1'b1, PA, 8'h10);
      apb(1'b1, PB, 8'h10);
      apb(1'b1, CA, 8'hf1);
      ticks(500);
      chw(1'b0, 1'b0);
      apb(1'b1, ST, 8'h07);
      ticks(40);
      chw(1'b1, 1'b1);
      apb(1'b0, ST, 8'h0);
      chk("ovf_bottom", 8'h01, rd & 8'h01);
      // compare equal to top: inverting output cleared at top
      apb(1'b1, PA, 8'hff);
      apb(1'b1, PB, 8'hff);
      ticks(800);
      chw(1'b0, 1'b0);
      complete_run();
   end
endmodule // tb_tmw_timer

// ===== tmw_apb_slave.sv
// apb slave front end: one wait-free access, write strobe and read mux
`timescale 1ns/1ps
`include "tmw_defines.svh"
module tmw_apb_slave (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire tmw_pkg::tmw_byte_t ctrl_a_rd,
   input wire tmw_pkg::tmw_byte_t ctrl_b_rd,
   input wire tmw_pkg::tmw_byte_t count_rd,
   input wire tmw_pkg::tmw_byte_t cmp_a_rd,
   input wire tmw_pkg::tmw_byte_t cmp_b_rd,
   input wire tmw_pkg::tmw_byte_t stat_rd,
   input wire tmw_pkg::tmw_byte_t mask_rd,
   output logic wr_en,
   output logic [11:0] wr_addr,
   output tmw_pkg::tmw_byte_t wr_data,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata
);
   import tmw_pkg::*;

   typedef struct packed {
      logic [31:0] rdata;
      logic err;
   } tmw_apb_s;

   tmw_apb_s st;
   tmw_apb_s next_st;
   logic setup;
   logic known;
   tmw_byte_t rd_byte;

   assign setup = psel && !penable;
   assign pready = 1'b1;
   assign prdata = st.rdata;
   assign pslverr = st.err;
   assign wr_en = ce && psel && penable && pwrite && known;
   assign wr_addr = paddr;
   assign wr_data = pwdata[7:0];

   ////////////////////////////////////////////////////////////////////////
   // address decode
   always_comb begin
      known = 1'b1;
      rd_byte = 8'h00;
      if (paddr == (`TMW_OFS_CTRL_A << 2)) begin
         rd_byte = ctrl_a_rd;
      end else if (paddr == (`TMW_OFS_CTRL_B << 2)) begin
         rd_byte = ctrl_b_rd;
      end else if (paddr == (`TMW_OFS_COUNT << 2)) begin
         rd_byte = count_rd;
      end else if (paddr == (`TMW_OFS_CMP_A << 2)) begin
         rd_byte = cmp_a_rd;
      end else if (paddr == (`TMW_OFS_CMP_B << 2)) begin
         rd_byte = cmp_b_rd;
      end else if (paddr == (`TMW_OFS_IRQ_STAT << 2)) begin
         rd_byte = stat_rd;
      end else if (paddr == (`TMW_OFS_IRQ_MASK << 2)) begin
         rd_byte = mask_rd;
      end else begin
         known = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // capture read data and error in the setup cycle
   always_comb begin
      next_st = st;
      if (setup) begin
         next_st.rdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         next_st.err = !known;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end
endmodule // tmw_apb_slave

// ===== tmw_defines.svh
// register offsets, field positions, reset values, write masks and interrupt bits
`ifndef TMW_DEFINES_SVH
`define TMW_DEFINES_SVH

`define TMW_OFS_CTRL_A 12'hb0
`define TMW_OFS_CTRL_B 12'hb1
`define TMW_OFS_CMP_A 12'hb3
`define TMW_OFS_CMP_B 12'hb4
`define TMW_OFS_COUNT 12'hb2
`define TMW_OFS_IRQ_STAT 12'hb8
`define TMW_OFS_IRQ_MASK 12'hb9
`define TMW_CTRL_A_WMASK 8'hf3
`define TMW_CTRL_B_WMASK 8'h08
`define TMW_MODE_HI_BIT 3
`define TMW_CHAN_A_LSB 6
`define TMW_CHAN_B_LSB 4
`define TMW_MAX 8'hff
`define TMW_BOTTOM 8'h00
`define TMW_RESET_BYTE 8'h00
`define TMW_IRQ_OVF 0
`define TMW_IRQ_CMPA 1
`define TMW_IRQ_CMPB 2
`define TMW_IRQ_WMASK 8'h07

`endif

// ===== tmw_pin_model.sv
// port pin model: direction bit, override mux and pull-up
`timescale 1ns/1ps
module tmw_pin_model (
   input wire logic override,
   input wire logic wave,
   input wire logic port_data,
   input wire logic dir,
   output logic pin
);
   // driver off unless direction set; undriven pin sits at pull-up
   assign pin = !dir ? 1'b1 : (override ? wave : port_data);
endmodule // tmw_pin_model

// ===== tmw_pkg.sv
// types shared by the waveform timer files
package tmw_pkg;

   typedef enum logic [1:0] {
      TMW_KIND_NORMAL,
      TMW_KIND_CTC,
      TMW_KIND_FAST,
      TMW_KIND_PHASE
   } tmw_kind_e;

   typedef logic [7:0] tmw_byte_t;

endpackage

// ===== tmw_timer.sv
// 8-bit waveform timer with mode control register and apb access
//
// Overview of operation
// - nonzero output field overrides port pin
// - non-pwm: toggle, clear or set on match
// - fast pwm channel a field actions
// - fast pwm channel b, 01 reserved
// - phase correct channel a field actions
// - phase correct channel b, 01 reserved
// - fast pwm compare at top ignored
// - phase correct compare at top acts at top
// - control a bits 3,2 read zero
// - three-bit mode selects kind and top
// - compare buffer update by mode
// - overflow flag point by mode
// - high mode bit in control b bit 3
`timescale 1ns/1ps
`include "tmw_defines.svh"
module tmw_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic tick,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   output logic chan_a_wave_out,
   output logic chan_b_wave_out,
   output logic chan_a_override,
   output logic chan_b_override,
   output logic irq
);
   import tmw_pkg::*;

   typedef struct packed {
      tmw_byte_t ctrl_a;
      logic mode_high;
      tmw_byte_t count;
      logic down;
      tmw_byte_t cmp_a_buf;
      tmw_byte_t cmp_b_buf;
      tmw_byte_t cmp_a;
      tmw_byte_t cmp_b;
      logic [2:0] stat;
      logic [2:0] mask;
      logic irq;
   } tmw_top_s;

   tmw_top_s st;
   tmw_top_s next_st;
   logic wr_en;
   logic [11:0] wr_addr;
   tmw_byte_t wr_data;
   logic [2:0] mode;
   tmw_kind_e kind;
   tmw_byte_t top;
   logic match_a;
   logic match_b;
   tmw_byte_t ctrl_b_rd;
   tmw_byte_t ctrl_a_rd;
   tmw_byte_t stat_rd;
   tmw_byte_t mask_rd;
   logic [1:0] chan_a_mode;
   logic [1:0] chan_b_mode;
   logic wr_ctrl_a;
   logic wr_ctrl_b;
   logic wr_count;
   logic wr_cmp_a;
   logic wr_cmp_b;
   logic wr_stat;
   logic wr_mask;

   ////////////////////////////////////////////////////////////////////////
   // mode decode
   assign mode = {st.mode_high, st.ctrl_a[1:0]};
   assign ctrl_b_rd = {4'h0, st.mode_high, 3'b000};

   always_comb begin
      kind = TMW_KIND_NORMAL;
      top = `TMW_MAX;
      case (mode)
         3'd1: kind = TMW_KIND_PHASE;
         3'd2: begin
            kind = TMW_KIND_CTC;
            top = st.cmp_a;
         end
         3'd3: kind = TMW_KIND_FAST;
         3'd5: begin
            kind = TMW_KIND_PHASE;
            top = st.cmp_a;
         end
         3'd7: begin
            kind = TMW_KIND_FAST;
            top = st.cmp_a;
         end
         default: kind = TMW_KIND_NORMAL; // reserved 4, 6 act as normal
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // field views and read values, reserved bits forced low
   assign chan_a_mode = st.ctrl_a[`TMW_CHAN_A_LSB +: 2];
   assign chan_b_mode = st.ctrl_a[`TMW_CHAN_B_LSB +: 2];
   assign ctrl_a_rd = st.ctrl_a & `TMW_CTRL_A_WMASK;
   assign stat_rd = {5'h00, st.stat};
   assign mask_rd = {5'h00, st.mask};

   ////////////////////////////////////////////////////////////////////////
   // bus front end
   tmw_apb_slave u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .ctrl_a_rd(ctrl_a_rd),
      .ctrl_b_rd(ctrl_b_rd),
      .count_rd(st.count),
      .cmp_a_rd(st.cmp_a_buf),
      .cmp_b_rd(st.cmp_b_buf),
      .stat_rd(stat_rd),
      .mask_rd(mask_rd),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .pready(pready),
      .pslverr(pslverr),
      .prdata(prdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // write strobe decode, one register per access
   always_comb begin
      wr_ctrl_a = 1'b0;
      wr_ctrl_b = 1'b0;
      wr_count = 1'b0;
      wr_cmp_a = 1'b0;
      wr_cmp_b = 1'b0;
      wr_stat = 1'b0;
      wr_mask = 1'b0;
      if (wr_en) begin
         if (wr_addr == (`TMW_OFS_CTRL_A << 2)) begin
            wr_ctrl_a = 1'b1;
         end else if (wr_addr == (`TMW_OFS_CTRL_B << 2)) begin
            wr_ctrl_b = 1'b1;
         end else if (wr_addr == (`TMW_OFS_COUNT << 2)) begin
            wr_count = 1'b1;
         end else if (wr_addr == (`TMW_OFS_CMP_A << 2)) begin
            wr_cmp_a = 1'b1;
         end else if (wr_addr == (`TMW_OFS_CMP_B << 2)) begin
            wr_cmp_b = 1'b1;
         end else if (wr_addr == (`TMW_OFS_IRQ_STAT << 2)) begin
            wr_stat = 1'b1;
         end else if (wr_addr == (`TMW_OFS_IRQ_MASK << 2)) begin
            wr_mask = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // compare output channels
   tmw_wave_chan u_chan_a (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .tick(tick),
      .kind(kind),
      .is_chan_a(1'b1),
      .mode_high(st.mode_high),
      .out_mode(chan_a_mode),
      .count(st.count),
      .top(top),
      .cmp(st.cmp_a),
      .counting_down(st.down),
      .match(match_a),
      .wave(chan_a_wave_out),
      .override(chan_a_override)
   );

   // channel b has no toggle choice in pwm modes
   tmw_wave_chan u_chan_b (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .tick(tick),
      .kind(kind),
      .is_chan_a(1'b0),
      .mode_high(st.mode_high),
      .out_mode(chan_b_mode),
      .count(st.count),
      .top(top),
      .cmp(st.cmp_b),
      .counting_down(st.down),
      .match(match_b),
      .wave(chan_b_wave_out),
      .override(chan_b_override)
   );

   // interrupt level straight from its flop
   assign irq = st.irq;

   ////////////////////////////////////////////////////////////////////////
   // counter, buffers, flags and register writes
   always_comb begin
      logic ovf;
      logic at_top;
      logic at_bottom;
      logic [2:0] w1c;
      ovf = 1'b0;
      w1c = 3'b000;
      at_top = (st.count == top);
      at_bottom = (st.count == `TMW_BOTTOM);
      next_st = st;
      if (tick) begin
         case (kind)
            TMW_KIND_PHASE: begin
               if (at_top) begin
                  next_st.down = 1'b1;
                  next_st.count = st.count - 8'h01;
               end else if (st.down && at_bottom) begin
                  next_st.down = 1'b0;
                  next_st.count = st.count + 8'h01;
                  ovf = 1'b1;
               end else begin
                  next_st.count = st.down ? st.count - 8'h01
                                          : st.count + 8'h01;
               end
               if (at_top) begin
                  next_st.cmp_a = st.cmp_a_buf;
                  next_st.cmp_b = st.cmp_b_buf;
               end
            end
            TMW_KIND_FAST: begin
               next_st.down = 1'b0;
               next_st.count = at_top ? `TMW_BOTTOM : st.count + 8'h01;
               // mode 7 at top, mode 3 at max
               ovf = mode[2] ? at_top : (st.count == `TMW_MAX);
               if (at_top) begin
                  next_st.cmp_a = st.cmp_a_buf;
                  next_st.cmp_b = st.cmp_b_buf;
               end
            end
            TMW_KIND_CTC: begin
               next_st.down = 1'b0;
               next_st.count = at_top ? `TMW_BOTTOM : st.count + 8'h01;
               ovf = (st.count == `TMW_MAX);
            end
            default: begin
               next_st.down = 1'b0;
               next_st.count = st.count + 8'h01;
               ovf = (st.count == `TMW_MAX);
            end
         endcase
      end
      // immediate compare update in non-pwm modes
      if (kind == TMW_KIND_NORMAL || kind == TMW_KIND_CTC) begin
         next_st.cmp_a = st.cmp_a_buf;
         next_st.cmp_b = st.cmp_b_buf;
      end
      // register writes; reserved bits of control a never stored
      if (wr_ctrl_a) begin
         next_st.ctrl_a = wr_data & `TMW_CTRL_A_WMASK;
      end
      if (wr_ctrl_b) begin
         next_st.mode_high = wr_data[`TMW_MODE_HI_BIT];
      end
      if (wr_count) begin
         next_st.count = wr_data;
      end
      if (wr_cmp_a) begin
         next_st.cmp_a_buf = wr_data;
      end
      if (wr_cmp_b) begin
         next_st.cmp_b_buf = wr_data;
      end
      if (wr_stat) begin
         w1c = wr_data[2:0];
      end
      if (wr_mask) begin
         next_st.mask = wr_data[2:0];
      end
      // sticky flags, a new event wins over the clear
      next_st.stat = (st.stat & ~w1c) | {match_b, match_a, ovf};
      next_st.irq = |(next_st.stat & next_st.mask);
   end

   ////////////////////////////////////////////////////////////////////////
   // state register, all fields zero on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end
endmodule // tmw_timer

// ===== tmw_timer_props.sv
// port assertions for the waveform timer
`timescale 1ns/1ps
`include "tmw_defines.svh"
module tmw_timer_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic tick,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   input wire logic chan_a_wave_out,
   input wire logic chan_b_wave_out,
   input wire logic chan_a_override,
   input wire logic chan_b_override,
   input wire logic irq
);
   localparam logic [11:0] A_CA = `TMW_OFS_CTRL_A << 2;
   localparam logic [11:0] A_CB = `TMW_OFS_CTRL_B << 2;
   logic acc;
   logic wr_a;
   // access phase and control a write decode
   assign acc = psel && penable;
   assign wr_a = acc && pwrite && ce && paddr == A_CA;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   a_ovr_a_field: assert property (
      wr_a ##1 (!wr_a) [*2] |-> chan_a_override == |$past(pwdata[7:6], 2))
      else $error("channel a override does not follow its field");
   a_ovr_b_field: assert property (
      wr_a ##1 (!wr_a) [*2] |-> chan_b_override == |$past(pwdata[5:4], 2))
      else $error("channel b override does not follow its field");
   a_ctrl_a_resv: assert property (
      acc && !pwrite && paddr == A_CA |-> prdata[3:2] == 2'b00 && !pslverr)
      else $error("control a reserved bits read nonzero");
   a_ctrl_b_bits: assert property (
      acc && !pwrite && paddr == A_CB |-> (prdata & 32'hffff_fff7) == 32'h0)
      else $error("control b reads bits beside the high mode bit");
   a_reset_clear: assert property (
      $rose(presetn) |-> !irq && !chan_a_override && !chan_b_override
         && !chan_a_wave_out && !chan_b_wave_out)
      else $error("outputs not cleared by reset");
   a_wave_a_tick: assert property (
      $changed(chan_a_wave_out) |-> $past(tick) && $past(ce))
      else $error("channel a wave moved without a tick");
   a_wave_b_tick: assert property (
      !tick |=> $stable(chan_b_wave_out))
      else $error("channel b wave moved without a tick");
   a_ce_freeze: assert property (
      !ce |=> $stable(irq) && $stable(chan_a_override))
      else $error("state moved with clock enable low");
   a_unmapped_err: assert property (
      acc && paddr == 12'h3fc |-> pslverr)
      else $error("unmapped access without error");
   a_ready_now: assert property (acc |-> pready)
      else $error("access phase without ready");
   a_rd_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits nonzero");
endmodule // tmw_timer_props

bind tmw_timer tmw_timer_props u_props (
   .pclk(pclk), .presetn(presetn), .ce(ce), .tick(tick), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .chan_a_wave_out(chan_a_wave_out), .chan_b_wave_out(chan_b_wave_out),
   .chan_a_override(chan_a_override), .chan_b_override(chan_b_override),
   .irq(irq)
);

// ===== tmw_wave_chan.sv
// one compare output channel: match detect, action and pin override
`timescale 1ns/1ps
`include "tmw_defines.svh"
module tmw_wave_chan (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic tick,
   input wire tmw_pkg::tmw_kind_e kind,
   input wire logic is_chan_a,
   input wire logic mode_high,
   input wire logic [1:0] out_mode,
   input wire tmw_pkg::tmw_byte_t count,
   input wire tmw_pkg::tmw_byte_t top,
   input wire tmw_pkg::tmw_byte_t cmp,
   input wire logic counting_down,
   output logic match,
   output logic wave,
   output logic override
);
   import tmw_pkg::*;

   typedef struct packed {
      logic wave;
      logic override;
      logic match;
   } tmw_chan_s;

   tmw_chan_s st;
   tmw_chan_s next_st;

   assign wave = st.wave;
   assign override = st.override;
   assign match = st.match;

   ////////////////////////////////////////////////////////////////////////
   // waveform action chosen by mode and field
   always_comb begin
      logic hit;
      logic at_top_special;
      hit = tick && (count == cmp);
      at_top_special = out_mode[1] && (cmp == top);
      next_st = st;
      next_st.match = hit;
      next_st.override = (out_mode != 2'b00);
      if (tick) begin
         case (kind)
            TMW_KIND_NORMAL, TMW_KIND_CTC: begin
               if (hit) begin
                  case (out_mode)
                     2'b01: next_st.wave = ~st.wave;
                     2'b10: next_st.wave = 1'b0;
                     2'b11: next_st.wave = 1'b1;
                     default: next_st.wave = st.wave;
                  endcase
               end
            end
            TMW_KIND_FAST: begin
               if (out_mode == 2'b01) begin
                  if (hit && is_chan_a && mode_high) begin
                     next_st.wave = ~st.wave;
                  end
               end else if (out_mode[1]) begin
                  // top match ignored, bottom still acts
                  if (count == `TMW_BOTTOM) begin
                     next_st.wave = ~out_mode[0];
                  end else if (hit && !at_top_special) begin
                     next_st.wave = out_mode[0];
                  end
               end
            end
            default: begin
               if (out_mode == 2'b01) begin
                  if (hit && is_chan_a && mode_high) begin
                     next_st.wave = ~st.wave;
                  end
               end else if (out_mode[1]) begin
                  if (at_top_special && count == top) begin
                     next_st.wave = ~out_mode[0]; // same level as bottom
                  end else if (hit && !at_top_special) begin
                     next_st.wave = counting_down ? ~out_mode[0]
                                                  : out_mode[0];
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end
endmodule // tmw_wave_chan
